// ---- rtl/dinit_ctrl.sv ----
// DDR2 power-up initialization sequencer with a Wishbone control port.
//
// Chosen here: the Wishbone interface to the registers and the placing of the registers.
`timescale 1ns/1ps
// ------------------------------------------------------------------
// Overview of operation
// RL1 - Drive NOP with CKE high for 200 us after start.
// RL2 - Wait at least 400 ns more, then PRECHARGE ALL.
// RL3 - Load EMR2 with BA0 low and BA1 high.
// RL4 - Load EMR3 with BA0 and BA1 both high.
// RL5 - Load EMR with BA0 high, A0 low: DLL enabled, E7-E9 zero.
// RL6 - Load MR with A8 high to reset DLL; CKE stays high.
// RL7 - Then PRECHARGE ALL, two REFRESH, one dummy WRITE.
// RL8 - Load MR with A8 low to set operating parameters.
// RL9 - Load EMR with E7-E9 set to one for calibration default.
// RL10 - Load EMR with E7-E9 cleared to exit calibration.
// RL11 - Report ready only 200 clocks after the DLL reset command.
// RL12 - Hold ODT low throughout power-up.
// RL13 - Mode register load uses bank bits 0,0.
// RL14 - Every mode load drives all address bits with defined values.
// RL15 - Device keeps mode bits; DLL reset bit self-clears.
// RL16 - Mode reload leaves memory array contents intact.
// RL17 - Mode loads only while all banks idle, no burst running.
// RL18 - Wait the mode-register-set delay after each mode load.
// RL19 - Burst length comes from low mode bits, four or eight only.
// RL20 - Bursts wrap inside an aligned block of the burst length.
// RL21 - Each 16-bit chip splits into lower and upper byte lanes.
// RL22 - Device samples commands on rising CK.
// RL23 - Drive NOP on every waiting cycle between steps.
// ------------------------------------------------------------------
module dinit_ctrl
  import dinit_pkg::*;
(
  // Clock, reset and enable
  input  wire logic                      clk_i,
  input  wire logic                      rst_i,
  input  wire logic                      ce_i,
  // Wishbone slave
  input  wire logic                      wb_cyc_i,
  input  wire logic                      wb_stb_i,
  input  wire logic                      wb_we_i,
  input  wire logic [3:0]                wb_adr_i,
  input  wire logic [3:0]                wb_sel_i,
  input  wire logic [31:0]               wb_dat_i,
  output logic      [31:0]               wb_dat_o,
  output logic                           wb_ack_o,
  // Memory command pins
  output logic                           mem_ck_o,
  output logic                           mem_ck_n_o,
  output logic                           mem_cke_o,
  output logic                           mem_odt_o,
  output logic                           mem_cs_n_o,
  output logic                           mem_ras_n_o,
  output logic                           mem_cas_n_o,
  output logic                           mem_we_n_o,
  output logic      [1:0]                mem_ba_o,
  output logic      [dinit_pkg::ADDR_W-1:0] mem_addr_o,
  // Status
  output logic                           ready_o
);
  import dinit_pkg::*;

  // ----------------------------------------------------------------
  // Registers
  // ----------------------------------------------------------------
  dinit_state_t       state_q;
  logic [CNT_W-1:0]   wait_q;
  logic [7:0]         lock_q;     // Counts clocks since the DLL reset load.
  logic               lock_run_q;
  logic [1:0]         ref_q;
  logic               start_q;
  logic [12:0]        mr_q;
  logic [12:0]        emr_q;
  logic [3:0]         cmd_d;
  logic [1:0]         ba_d;
  logic [ADDR_W-1:0]  addr_d;
  logic               fire;       // Step issues its command this cycle.
  logic               step;       // This clk_i edge drops CK.

  assign fire = (wait_q == '0);

  // RL22 command phase
  // Pins, sequencer and lock timer move only on the clk_i edge that drops
  // CK. Each command then stands a whole CK period and is steady across
  // the CK rise at which the device takes it. The price is that every wait
  // below counts CK periods, twice as long as clk_i cycles, so the
  // package derives its cycle counts from the CK period.
  assign step = mem_ck_o;

  // ----------------------------------------------------------------
  // Wishbone slave: single-cycle ack, unmapped reads return zero
  // ----------------------------------------------------------------
  always_ff @(posedge clk_i) begin
    if (rst_i) begin
      wb_ack_o <= 1'b0;
      wb_dat_o <= 32'h0;
      start_q  <= 1'b0;
      mr_q     <= MR_RST;
      emr_q    <= EMR_RST;
    end else if (ce_i) begin
      wb_ack_o <= wb_cyc_i & wb_stb_i & ~wb_ack_o;
      if (state_q != ST_IDLE) begin
        start_q <= 1'b0;  // Start is consumed once the sequence runs.
      end
      if (wb_cyc_i && wb_stb_i && !wb_ack_o) begin
        wb_dat_o <= 32'h0;
        unique case (wb_adr_i)
          REG_CTRL: wb_dat_o <= {31'h0, start_q};
          REG_STAT: wb_dat_o <= {16'h0, 2'h0, state_q[13:0]} | {15'h0, ready_o, 16'h0};
          REG_MR:   wb_dat_o <= {19'h0, mr_q};
          REG_EMR:  wb_dat_o <= {19'h0, emr_q};
          default:  wb_dat_o <= 32'h0;
        endcase
        if (wb_we_i && wb_sel_i[0]) begin
          unique case (wb_adr_i)
            REG_CTRL: if (wb_dat_i[CTRL_START] && state_q == ST_IDLE) start_q <= 1'b1;
            REG_MR:   if (state_q == ST_IDLE) mr_q[7:0] <= wb_dat_i[7:0];
            REG_EMR:  if (state_q == ST_IDLE) emr_q[7:0] <= wb_dat_i[7:0];
            default:  ;
          endcase
        end
        if (wb_we_i && wb_sel_i[1] && state_q == ST_IDLE) begin
          if (wb_adr_i == REG_MR)  mr_q[12:8]  <= wb_dat_i[12:8];
          if (wb_adr_i == REG_EMR) emr_q[12:8] <= wb_dat_i[12:8];
        end
      end
    end
  end

  // ----------------------------------------------------------------
  // Memory clock: divided by two so CK rises mid-command cycle pair
  // ----------------------------------------------------------------
  // CK runs freely while enabled, since the device needs it in every wait;
  // only reset or a low ce_i stops it.
  // RL22 rising CK
  always_ff @(posedge clk_i) begin
    if (rst_i) begin
      mem_ck_o   <= 1'b0;
      mem_ck_n_o <= 1'b1;
    end else if (ce_i) begin
      mem_ck_o   <= ~mem_ck_o;
      mem_ck_n_o <= mem_ck_o;
    end
  end

  // ----------------------------------------------------------------
  // Command decode per state
  // ----------------------------------------------------------------
  // Outside a fire cycle every step issues NOP, so waits stay clean.
  always_comb begin
    cmd_d  = CMD_NOP;
    ba_d   = BA_MR;
    addr_d = '0;
    if (fire) begin
      unique case (state_q)
        // RL2 precharge all
        ST_PALL1, ST_PALL2: begin
          cmd_d = CMD_PRE;
          addr_d[A_PALL] = 1'b1;
        end
        // RL3 load EMR2
        ST_EMR2: begin cmd_d = CMD_LMR; ba_d = BA_EMR2; end
        // RL4 load EMR3
        ST_EMR3: begin cmd_d = CMD_LMR; ba_d = BA_EMR3; end
        // RL5 DLL enable
        ST_DLLEN: begin
          cmd_d  = CMD_LMR;
          ba_d   = BA_EMR;
          addr_d = emr_q & ~(13'h7 << A_OCD_LO) & ~(13'h1 << A_DLL_DIS);
        end
        // RL6 DLL reset
        ST_DLLRST: begin
          cmd_d  = CMD_LMR;
          ba_d   = BA_MR;
          addr_d = mr_q | (13'h1 << A_DLL_RST);
        end
        // RL7 refresh
        ST_REF: cmd_d = CMD_REF;
        ST_DWR: cmd_d = CMD_WR;
        // RL8 RL13 RL14 full mode word
        ST_MR: begin
          cmd_d  = CMD_LMR;
          ba_d   = BA_MR;
          addr_d = mr_q & ~(13'h1 << A_DLL_RST);
        end
        // RL9 calibration default
        ST_OCDDEF: begin
          cmd_d  = CMD_LMR;
          ba_d   = BA_EMR;
          addr_d = (emr_q | (13'h7 << A_OCD_LO)) & ~(13'h1 << A_DLL_DIS);
        end
        // RL10 calibration exit
        ST_OCDEX: begin
          cmd_d  = CMD_LMR;
          ba_d   = BA_EMR;
          addr_d = emr_q & ~(13'h7 << A_OCD_LO) & ~(13'h1 << A_DLL_DIS);
        end
        ST_IDLE, ST_STABLE, ST_DONE: cmd_d = CMD_NOP;
        default: cmd_d = CMD_NOP;
      endcase
    end
  end

  // ----------------------------------------------------------------
  // Pin registers: every output comes from a flop
  // ----------------------------------------------------------------
  // Pins move on step edges only; between them the current command simply
  // stands through the CK rise that follows.
  always_ff @(posedge clk_i) begin
    if (rst_i) begin
      {mem_cs_n_o, mem_ras_n_o, mem_cas_n_o, mem_we_n_o} <= CMD_DESEL;
      mem_ba_o   <= 2'h0;
      mem_addr_o <= '0;
      mem_cke_o  <= 1'b0;
      mem_odt_o  <= 1'b0;
    end else if (ce_i && step) begin
      // RL23 NOP while waiting
      {mem_cs_n_o, mem_ras_n_o, mem_cas_n_o, mem_we_n_o} <= cmd_d;
      mem_ba_o   <= ba_d;
      mem_addr_o <= addr_d;
      // RL1 RL6 CKE high
      mem_cke_o  <= (state_q != ST_IDLE);
      // RL12 ODT low
      mem_odt_o  <= 1'b0;
    end
  end

  // ----------------------------------------------------------------
  // Step sequencer; wait_q is the gap before the next step's command
  // ----------------------------------------------------------------
  // Each step loads its own wait, so mode loads are spaced by tMRD and
  // nothing is issued while a precharge or refresh is still running.
  // Waits count CK periods, since they advance only on step edges.
  always_ff @(posedge clk_i) begin
    if (rst_i) begin
      state_q <= ST_IDLE;
      wait_q  <= '0;
      ref_q   <= 2'h0;
    end else if (ce_i && step) begin
      if (!fire) begin
        wait_q <= wait_q - 1'b1;
      end else begin
        unique case (state_q)
          ST_IDLE: if (start_q) begin
            state_q <= ST_STABLE;
            // RL1 200 us hold
            wait_q  <= CNT_W'(T_STABLE_CYC - 1);
          end
          ST_STABLE: begin
            state_q <= ST_PALL1;
            // RL2 400 ns gap
            wait_q  <= CNT_W'(T_PRE_PALL_CYC);
          end
          // RL17 banks idle first
          ST_PALL1:  begin state_q <= ST_EMR2;   wait_q <= CNT_W'(T_RP_CYC);  end
          // RL18 tMRD gap
          ST_EMR2:   begin state_q <= ST_EMR3;   wait_q <= CNT_W'(T_MRD_CYC); end
          ST_EMR3:   begin state_q <= ST_DLLEN;  wait_q <= CNT_W'(T_MRD_CYC); end
          ST_DLLEN:  begin state_q <= ST_DLLRST; wait_q <= CNT_W'(T_MRD_CYC); end
          ST_DLLRST: begin state_q <= ST_PALL2;  wait_q <= CNT_W'(T_MRD_CYC); end
          ST_PALL2: begin
            state_q <= ST_REF;
            wait_q  <= CNT_W'(T_RP_CYC);
            ref_q   <= 2'h0;
          end
          // RL7 two refreshes
          ST_REF: begin
            wait_q <= CNT_W'(T_RFC_CYC);
            ref_q  <= ref_q + 2'h1;
            if (ref_q == 2'(N_REFRESH - 1)) state_q <= ST_DWR;
          end
          ST_DWR:    begin state_q <= ST_MR;     wait_q <= CNT_W'(T_WR_CYC);  end
          ST_MR:     begin state_q <= ST_OCDDEF; wait_q <= CNT_W'(T_MRD_CYC); end
          ST_OCDDEF: begin state_q <= ST_OCDEX;  wait_q <= CNT_W'(T_MRD_CYC); end
          ST_OCDEX:  begin state_q <= ST_DONE;   wait_q <= CNT_W'(T_MRD_CYC); end
          ST_DONE:   state_q <= ST_DONE;
          default:   state_q <= ST_IDLE;
        endcase
      end
    end
  end

  // ----------------------------------------------------------------
  // DLL lock timer and ready flag
  // ----------------------------------------------------------------
  // The count runs in CK periods, the clock that the DLL locks to. Once set,
  // ready_o stays high: DONE keeps firing and the count saturates at 200.
  // RL11 200 clocks after DLL reset
  always_ff @(posedge clk_i) begin
    if (rst_i) begin
      lock_q     <= 8'h0;
      lock_run_q <= 1'b0;
      ready_o    <= 1'b0;
    end else if (ce_i && step) begin
      if (state_q == ST_DLLRST && fire) begin
        lock_q     <= 8'h0;
        lock_run_q <= 1'b1;
      end else if (lock_run_q && lock_q != 8'(T_DLL_LOCK_CYC)) begin
        lock_q <= lock_q + 8'h1;
      end
      ready_o <= (state_q == ST_DONE) && fire && lock_run_q &&
                 (lock_q == 8'(T_DLL_LOCK_CYC));
    end
  end

endmodule : dinit_ctrl

// ---- rtl/dinit_pkg.sv ----
// Constants for the DDR2 power-up initialization sequencer.
package dinit_pkg;

  // ----------------------------------------------------------------
  // Clock and timing
  // ----------------------------------------------------------------
  localparam int unsigned CLK_PERIOD_PS    = 5000;
  // Waits are counted in CK periods; CK is clk_i divided by two.
  localparam int unsigned CK_PERIOD_PS     = 2 * CLK_PERIOD_PS;
  localparam int unsigned T_STABLE_US      = 200;
  localparam int unsigned T_STABLE_CYC     = (T_STABLE_US * 1000000) / CK_PERIOD_PS;
  localparam int unsigned T_PRE_PALL_NS    = 400;
  localparam int unsigned T_PRE_PALL_CYC   = (T_PRE_PALL_NS * 1000 + CK_PERIOD_PS - 1)
                                             / CK_PERIOD_PS;
  localparam int unsigned T_DLL_LOCK_CYC   = 200;
  localparam int unsigned T_MRD_CYC        = 2;
  localparam int unsigned T_RP_CYC         = 4;
  localparam int unsigned T_RFC_CYC        = 26;
  localparam int unsigned T_WR_CYC         = 8;
  localparam int unsigned N_REFRESH        = 2;
  localparam int unsigned CNT_W            = 16;

  // ----------------------------------------------------------------
  // Command encodings {cs_n, ras_n, cas_n, we_n}
  // ----------------------------------------------------------------
  localparam logic [3:0] CMD_NOP   = 4'h7;
  localparam logic [3:0] CMD_DESEL = 4'hf;
  localparam logic [3:0] CMD_PRE   = 4'h2;
  localparam logic [3:0] CMD_REF   = 4'h1;
  localparam logic [3:0] CMD_LMR   = 4'h0;
  localparam logic [3:0] CMD_WR    = 4'h4;

  // ----------------------------------------------------------------
  // Bank selects and address bit positions
  // ----------------------------------------------------------------
  localparam logic [1:0] BA_MR   = 2'h0;
  localparam logic [1:0] BA_EMR  = 2'h1;
  localparam logic [1:0] BA_EMR2 = 2'h2;
  localparam logic [1:0] BA_EMR3 = 2'h3;
  localparam int unsigned A_DLL_RST = 8;
  localparam int unsigned A_PALL    = 10;
  localparam int unsigned A_DLL_DIS = 0;
  localparam int unsigned A_OCD_LO  = 7;
  localparam int unsigned ADDR_W    = 13;

  // ----------------------------------------------------------------
  // Wishbone register map (word index = adr[3:2])
  // ----------------------------------------------------------------
  localparam logic [3:0] REG_CTRL  = 4'h0;
  localparam logic [3:0] REG_STAT  = 4'h4;
  localparam logic [3:0] REG_MR    = 4'h8;
  localparam logic [3:0] REG_EMR   = 4'hc;
  localparam int unsigned CTRL_START = 0;
  localparam logic [12:0] MR_RST     = 13'h0432;
  localparam logic [12:0] EMR_RST    = 13'h0000;

  // ----------------------------------------------------------------
  // Sequencer states
  // ----------------------------------------------------------------
  typedef enum logic [13:0] {
    ST_IDLE   = 14'h0001,
    ST_STABLE = 14'h0002,
    ST_PALL1  = 14'h0004,
    ST_EMR2   = 14'h0008,
    ST_EMR3   = 14'h0010,
    ST_DLLEN  = 14'h0020,
    ST_DLLRST = 14'h0040,
    ST_PALL2  = 14'h0080,
    ST_REF    = 14'h0100,
    ST_DWR    = 14'h0200,
    ST_MR     = 14'h0400,
    ST_OCDDEF = 14'h0800,
    ST_OCDEX  = 14'h1000,
    ST_DONE   = 14'h2000
  } dinit_state_t;

endpackage : dinit_pkg

// ---- verif/dinit_dev_model.sv ----
// Behavioural DDR2 device: mode registers and DLL lock timer.
`timescale 1ns/1ps
module dinit_dev_model
  import dinit_pkg::*;
(
  // Command pins in, stored state out
  input  wire logic        clk_i,
  input  wire logic [3:0]  cmd_i,
  input  wire logic [1:0]  ba_i,
  input  wire logic [12:0] addr_i,
  output logic      [12:0] mr_o,
  output logic      [12:0] emr_o,
  output logic      [3:0]  bl_o,
  output logic             locked_o
);
  logic [15:0] lock_q = 16'h0000;
  logic        seen_q = 1'b0;
  // loads touch mode state only; the model holds no array to disturb.
  // load on rising edge; M8 is a one-shot, so it never stays set.
  always_ff @(posedge clk_i) begin
    if (cmd_i == CMD_LMR && ba_i == BA_MR) mr_o <= addr_i & 13'h1eff;
    if (cmd_i == CMD_LMR && ba_i == BA_EMR) emr_o <= addr_i;
  end
  always_ff @(posedge clk_i) begin
    if (cmd_i == CMD_LMR && ba_i == BA_MR && addr_i[A_DLL_RST]) begin
      lock_q <= 16'h0000;
      seen_q <= 1'b1;
    end else if (lock_q != 16'hffff) begin
      lock_q <= lock_q + 16'h0001;
    end
  end
  assign locked_o = seen_q && (lock_q >= 16'(T_DLL_LOCK_CYC - 1));
  // byte lanes are not modelled: the init sequence moves no data.
  // burst length four or eight; it also sets the wrap block size.
  assign bl_o = (mr_o[2:0] == 3'h3) ? 4'h8 : 4'h4;
endmodule : dinit_dev_model

// ---- verif/dinit_ctrl_chk.sv ----
// Concurrent checks on the init sequencer's memory pins.
`timescale 1ns/1ps
module dinit_ctrl_chk
  import dinit_pkg::*;
(
  // Watched ports
  input wire logic        clk_i,
  input wire logic        rst_i,
  input wire logic        wb_ack_o,
  input wire logic        mem_ck_o,
  input wire logic        mem_ck_n_o,
  input wire logic        mem_cke_o,
  input wire logic        mem_odt_o,
  input wire logic        mem_cs_n_o,
  input wire logic        mem_ras_n_o,
  input wire logic        mem_cas_n_o,
  input wire logic        mem_we_n_o,
  input wire logic [1:0]  mem_ba_o,
  input wire logic [12:0] mem_addr_o,
  input wire logic        ready_o
);
  logic [3:0]  cmd;
  logic        is_cmd, is_lm;
  // CK stands still during reset, so the counters start from declared values.
  logic        any_q = 1'b0, dll_q = 1'b0;
  logic [3:0]  last_q = CMD_NOP;
  logic [15:0] cke_q = 16'h0000, gap_q = 16'h0000, dll_cnt_q = 16'h0000;
  assign cmd = {mem_cs_n_o, mem_ras_n_o, mem_cas_n_o, mem_we_n_o};
  assign is_cmd = (cmd != CMD_NOP) && (cmd != CMD_DESEL);
  assign is_lm = (cmd == CMD_LMR);
  // Saturating CK-period counters; saturation keeps long idles from wrapping to zero.
  // They run on CK because the device takes one command per CK rise.
  always @(posedge mem_ck_o) begin
    if (rst_i) begin
      cke_q <= 16'h0000;
      gap_q <= 16'h0000;
      dll_cnt_q <= 16'h0000;
      any_q <= 1'b0;
      dll_q <= 1'b0;
      last_q <= CMD_NOP;
    end else begin
      if (mem_cke_o && cke_q != 16'hffff) cke_q <= cke_q + 16'h0001;
      gap_q <= is_cmd ? 16'h0000 : ((gap_q == 16'hffff) ? gap_q : gap_q + 16'h0001);
      if (is_cmd) last_q <= cmd;
      if (is_cmd) any_q <= 1'b1;
      if (is_lm && mem_ba_o == BA_MR) dll_q <= 1'b1;
      if (is_lm && mem_ba_o == BA_MR && !dll_q) dll_cnt_q <= 16'h0000;
      else if (dll_cnt_q != 16'hffff) dll_cnt_q <= dll_cnt_q + 16'h0001;
    end
  end
  default clocking cb @(posedge mem_ck_o); endclocking
  default disable iff (rst_i);
  property p_odt_low; mem_odt_o == 1'b0; endproperty
  a_odt_low: assert property (p_odt_low) else $error("odt high");
  property p_ck_pair; @(posedge clk_i) mem_ck_o != mem_ck_n_o; endproperty
  a_ck_pair: assert property (p_ck_pair) else $error("ck not complementary");
  property p_cke_hold; mem_cke_o |=> mem_cke_o; endproperty
  a_cke_hold: assert property (p_cke_hold) else $error("cke dropped");
  property p_cke_first; !mem_cke_o |-> !is_cmd; endproperty
  a_cke_first: assert property (p_cke_first) else $error("command with cke low");
  property p_first_pre;
    (is_cmd && !any_q) |-> cmd == CMD_PRE && mem_addr_o[A_PALL]
      && cke_q >= T_STABLE_CYC + T_PRE_PALL_CYC;
  endproperty
  a_first_pre: assert property (p_first_pre) else $error("early first precharge");
  property p_mrd; (is_cmd && last_q == CMD_LMR) |-> gap_q >= T_MRD_CYC - 1; endproperty
  a_mrd: assert property (p_mrd) else $error("mode load gap short");
  property p_rfc; (is_cmd && last_q == CMD_REF) |-> gap_q >= T_RFC_CYC - 1; endproperty
  a_rfc: assert property (p_rfc) else $error("refresh gap short");
  property p_rp; (is_cmd && last_q == CMD_PRE) |-> gap_q >= T_RP_CYC - 1; endproperty
  a_rp: assert property (p_rp) else $error("precharge gap short");
  property p_dll_rst; (is_lm && mem_ba_o == BA_MR) |-> mem_addr_o[A_DLL_RST] == !dll_q;
  endproperty
  a_dll_rst: assert property (p_dll_rst) else $error("wrong DLL reset bit");
  property p_ocd; (is_lm && mem_ba_o == BA_EMR) |-> mem_addr_o[9:7] inside {3'h0, 3'h7};
  endproperty
  a_ocd: assert property (p_ocd) else $error("calibration bits split");
  property p_ready; $rose(ready_o) |-> dll_q && dll_cnt_q >= T_DLL_LOCK_CYC - 1; endproperty
  a_ready: assert property (p_ready) else $error("ready before DLL lock");
  c_ready: cover property ($rose(ready_o));
  c_dll: cover property (is_lm && mem_addr_o[A_DLL_RST]);
  c_ack: cover property (@(posedge clk_i) wb_ack_o);
endmodule : dinit_ctrl_chk

// ---- verif/dinit_ctrl_test.sv ----
// Self-checking bench for the DDR2 init sequencer.
`timescale 1ns/1ps
module dinit_ctrl_test;
  import dinit_pkg::*;
  logic clk_i = 1'b0, rst_i = 1'b1, ce_i = 1'b1;
  logic wb_cyc_i = 1'b0, wb_stb_i = 1'b0, wb_we_i = 1'b0;
  logic [3:0] wb_adr_i = 4'h0, wb_sel_i = 4'h0, c, bl_m;
  logic [31:0] wb_dat_i = 32'h0, wb_dat_o, exp_rd[$], exp_cmd[$];
  logic wb_ack_o, mem_ck_o, mem_ck_n_o, mem_cke_o, mem_odt_o, ready_o, locked_m;
  logic mem_cs_n_o, mem_ras_n_o, mem_cas_n_o, mem_we_n_o;
  logic [1:0] mem_ba_o;
  logic [12:0] mem_addr_o, mr_m, emr_m, mr_v, emr_v;
  integer seed = 27, bad_count = 0, n_compared = 0, i;
  always #2.5 clk_i = ~clk_i;
  dinit_ctrl u_dinit_ctrl (.clk_i, .rst_i, .ce_i, .wb_cyc_i, .wb_stb_i, .wb_we_i, .wb_adr_i,
    .wb_sel_i, .wb_dat_i, .wb_dat_o, .wb_ack_o, .mem_ck_o, .mem_ck_n_o, .mem_cke_o, .mem_odt_o,
    .mem_cs_n_o, .mem_ras_n_o, .mem_cas_n_o, .mem_we_n_o, .mem_ba_o, .mem_addr_o, .ready_o);
  dinit_dev_model u_dinit_dev_model (.clk_i(mem_ck_o), .cmd_i({mem_cs_n_o, mem_ras_n_o,
    mem_cas_n_o, mem_we_n_o}), .ba_i(mem_ba_o), .addr_i(mem_addr_o), .mr_o(mr_m),
    .emr_o(emr_m), .bl_o(bl_m), .locked_o(locked_m));
  task automatic give_verdict;
    $display("compared %0d errors %0d", n_compared, bad_count);
    if (bad_count == 0 && n_compared > 0) $display("[ PASS ]");
    else $display("[ FAIL ]");
    $finish;
  endtask : give_verdict
  task automatic check(input logic [31:0] got, input logic [31:0] exp);
    n_compared++;
    if (got !== exp) begin
      bad_count++;
      $display("ERROR %0t: got %h expected %h", $time, got, exp);
    end
  endtask : check
  function automatic logic [31:0] mk(input logic [3:0] k, input logic [1:0] b,
                                     input logic [12:0] a);
    return {13'h0000, k, b, a};
  endfunction : mk
  // One classic cycle; the request is held until ack is sampled high.
  task automatic wb(input logic we, input logic [3:0] adr, input logic [31:0] dat);
    integer n;
    @(posedge clk_i);
    wb_cyc_i <= 1'b1;
    wb_stb_i <= 1'b1;
    wb_we_i <= we;
    wb_adr_i <= adr;
    wb_dat_i <= dat;
    wb_sel_i <= 4'hf;
    n = 0;
    do begin
      @(posedge clk_i);
      n++;
    end while (wb_ack_o !== 1'b1 && n < 20);
    if (n >= 20) begin
      bad_count++;
      give_verdict();
    end
    wb_cyc_i <= 1'b0;
    wb_stb_i <= 1'b0;
    wb_we_i <= 1'b0;
  endtask : wb
  task automatic rd(input logic [3:0] adr, input logic [31:0] exp);
    exp_rd.push_back(exp);
    wb(1'b0, adr, 32'h0);
  endtask : rd
  // Result watcher: each read answer and each memory command takes the oldest note.
  always @(posedge clk_i) begin
    c = {mem_cs_n_o, mem_ras_n_o, mem_cas_n_o, mem_we_n_o};
    if (wb_ack_o === 1'b1 && wb_we_i === 1'b0) check(wb_dat_o, exp_rd.pop_front());
    // A command counts once, at the edge where CK rises, as the device takes it.
    if (rst_i === 1'b0 && ce_i === 1'b1 && mem_ck_o === 1'b0 && c !== CMD_NOP &&
        c !== CMD_DESEL) begin
      check(mk(c, (c == CMD_LMR) ? mem_ba_o : 2'h0, (c == CMD_LMR) ? mem_addr_o :
        ((c == CMD_PRE) ? (mem_addr_o & 13'h0400) : 13'h0000)),
        (exp_cmd.size() > 0) ? exp_cmd.pop_front() : 32'hffffffff);
    end
  end
  initial begin
    repeat (5) @(posedge clk_i);
    rst_i <= 1'b0;
    rd(REG_MR, {19'h0, MR_RST});
    rd(REG_EMR, {19'h0, EMR_RST});
    mr_v = (13'($random(seed)) & 13'h1f78) | (13'($random(seed)) & 13'h0001) | 13'h0002;
    emr_v = 13'($random(seed)) & 13'h1ffe;
    wb(1'b1, REG_MR, {19'h0, mr_v});
    wb(1'b1, REG_EMR, {19'h0, emr_v});
    rd(REG_MR, {19'h0, mr_v});
    exp_cmd = '{mk(CMD_PRE, 2'h0, 13'h0400), mk(CMD_LMR, BA_EMR2, 13'h0),
      mk(CMD_LMR, BA_EMR3, 13'h0), mk(CMD_LMR, BA_EMR, emr_v & ~13'h0381),
      mk(CMD_LMR, BA_MR, mr_v | 13'h0100), mk(CMD_PRE, 2'h0, 13'h0400),
      mk(CMD_REF, 2'h0, 13'h0), mk(CMD_REF, 2'h0, 13'h0), mk(CMD_WR, 2'h0, 13'h0),
      mk(CMD_LMR, BA_MR, mr_v & ~13'h0100), mk(CMD_LMR, BA_EMR, emr_v | 13'h0380),
      mk(CMD_LMR, BA_EMR, emr_v & ~13'h0380)};
    wb(1'b1, REG_CTRL, 32'h1);
    rd(REG_STAT, 32'h0000_0002);
    // A busy sequencer ignores mode writes; the freeze only stretches the wait.
    wb(1'b1, REG_MR, {19'h0, ~mr_v});
    rd(REG_MR, {19'h0, mr_v});
    ce_i <= 1'b0;
    repeat (10) @(posedge clk_i);
    ce_i <= 1'b1;
    for (i = 0; i < 60000 && ready_o !== 1'b1; i++) @(posedge clk_i);
    if (ready_o !== 1'b1) begin
      bad_count++;
      give_verdict();
    end
    check({31'h0, locked_m}, 32'h1);
    repeat (4) @(posedge clk_i);
    check({31'h0, exp_cmd.size() == 0}, 32'h1);
    check({19'h0, mr_m}, {19'h0, mr_v & ~13'h0100});
    check({19'h0, emr_m}, {19'h0, emr_v & ~13'h0380});
    check({28'h0, bl_m}, (mr_v[0] ? 32'h8 : 32'h4));
    rd(REG_STAT, 32'h0001_2000);
    give_verdict();
  end
endmodule : dinit_ctrl_test
bind dinit_ctrl dinit_ctrl_chk u_dinit_ctrl_chk (.clk_i, .rst_i, .wb_ack_o, .mem_ck_o,
  .mem_ck_n_o, .mem_cke_o, .mem_odt_o, .mem_cs_n_o, .mem_ras_n_o, .mem_cas_n_o, .mem_we_n_o,
  .mem_ba_o, .mem_addr_o, .ready_o);
